// file: inc/cvj_pkg.sv
// Shared constants for the jack-pin verb block: link framing, node ids, verbs,
// field positions, reset values and host register map.
// Assumes both ends run on one 40 MHz system clock; the host makes the link clock.
//
// Function
// - Supply register: get FE6, set 7E6 low byte
// - Supply bit 7: tenfold faster reference ramp
// - Supply bits 6:5 pick analog current trim
// - Supply bit 4: input buffer level, resets one
// - Supply bits 3:0: invert, force, force-enable
// - Microphone control: get FF0, set 7F0, four bits
// - Microphone bits 3:2 choose data latch phase
// - Microphone bits 1:0 choose clock rate, reset 2
// - Set 7FF payload 00: answer, then reset group
// - Function reset spares configuration default controls
// - Widget capabilities: pin complex, list, events, stereo
// - Pin capabilities: bias 0x17, io, headphone, sensing
// - List length: short form, two or one
// - List read: 0x10, then 0x11 if enabled
// - Source select bit 0 via 701/F01, reset zero
// - Pin control 707: headphone, output, input enables
// - Unlisted bias code is stored as 000b
// - Event enable: report insertion and sense completion
// - Event tag fills response bits 31:26
// - Sense read: presence bit 31, impedance below
// - Sense write 709 starts measurement, bit0 side
// - Set verbs apply low byte, answer zero

package cvj_pkg;
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int LINK_CLK_HZ = 5_000_000;
    localparam int LINK_HALF = SYS_CLK_HZ / (2 * LINK_CLK_HZ);
    localparam int CMD_BITS = 28;
    localparam int RSP_BITS = 33;
    localparam int TX_BITS = RSP_BITS + 1;

    localparam logic [7:0] AFG_NID = 8'h01;
    localparam logic [7:0] PIN_NID = 8'h0a;

    localparam logic [11:0] V_GET_SUPPLY = 12'hfe6;
    localparam logic [11:0] V_SET_SUPPLY = 12'h7e6;
    localparam logic [11:0] V_GET_MIC = 12'hff0;
    localparam logic [11:0] V_SET_MIC = 12'h7f0;
    localparam logic [11:0] V_FG_RESET = 12'h7ff;
    localparam logic [11:0] V_GET_PARAM = 12'hf00;
    localparam logic [11:0] V_GET_SEL = 12'hf01;
    localparam logic [11:0] V_GET_LIST = 12'hf02;
    localparam logic [11:0] V_SET_SEL = 12'h701;
    localparam logic [11:0] V_GET_PINCTL = 12'hf07;
    localparam logic [11:0] V_SET_PINCTL = 12'h707;
    localparam logic [11:0] V_GET_EVENT = 12'hf08;
    localparam logic [11:0] V_SET_EVENT = 12'h708;
    localparam logic [11:0] V_GET_SENSE = 12'hf09;
    localparam logic [11:0] V_SET_SENSE = 12'h709;

    localparam logic [7:0] P_WIDGET_CAPS = 8'h09;
    localparam logic [7:0] P_PIN_CAPS = 8'h0c;
    localparam logic [7:0] P_LIST_LEN = 8'h0e;
    localparam logic [7:0] P_RESET_EXEC = 8'h00;

    localparam logic [31:0] WIDGET_CAPS_VAL = 32'h0040_0181;
    localparam logic [7:0] BIAS_OPTIONS = 8'h17;
    localparam logic [31:0] PIN_CAPS_VAL = {16'h0000, BIAS_OPTIONS, 8'h3f};
    localparam logic [6:0] LIST_LEN_TWO = 7'h02;
    localparam logic [6:0] LIST_LEN_ONE = 7'h01;
    localparam logic [7:0] FIRST_CONVERTER = 8'h10;
    localparam logic [7:0] SECOND_CONVERTER = 8'h11;

    localparam logic [7:0] SUPPLY_RST = 8'h10;
    localparam logic [3:0] MIC_RST = 4'h2;
    localparam logic [30:0] IMPEDANCE_NONE = 31'h7fff_ffff;

    localparam int SUP_RAMP_BIT = 7;
    localparam int SUP_TRIM_LSB = 5;
    localparam int SUP_LEVEL_BIT = 4;
    localparam int MIC_PHASE_LSB = 2;
    localparam int PIN_HP_BIT = 7;
    localparam int PIN_OUT_BIT = 6;
    localparam int PIN_IN_BIT = 5;
    localparam int EVT_EN_BIT = 7;
    localparam int TAG_LSB = 26;

    localparam logic [7:0] HA_CMD = 8'h00;
    localparam logic [7:0] HA_STATUS = 8'h04;
    localparam logic [7:0] HA_RESP = 8'h08;
    localparam logic [7:0] HA_EVENT = 8'h0c;
    localparam int ST_BUSY = 0;
    localparam int ST_RESP = 1;
    localparam int ST_EVENT = 2;
endpackage : cvj_pkg

// file: inc/cvj_link_if.sv
// Serial verb link between the controller end and the codec end.
// Assumes the controller drives the bit clock; both ends use one system clock.
`timescale 1ns/100ps
interface cvj_link_if;
    logic bclk;
    logic sync;
    logic sdo;
    logic sdi;

    modport dev (
        input bclk,
        input sync,
        input sdo,
        output sdi
    );

    modport host (
        output bclk,
        output sync,
        output sdo,
        input sdi
    );
endinterface : cvj_link_if

// file: design/cvj_codec.sv
// Codec end: verb decoder, vendor controls and front jack pin node.
// Assumes link lines come from another domain; sense result comes from local logic.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
module cvj_codec (
    // System
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Link
    cvj_link_if.dev link,
    // Jack and strap pins
    input wire logic i_jack_present,
    input wire logic i_second_converter_on,
    // Impedance measurement result
    input wire logic i_sense_valid,
    input wire logic [30:0] i_sense_value,
    // Supply controls
    output logic o_anti_pop_fast_ramp,
    output logic [1:0] o_analog_current_trim,
    output logic o_digital_audio_input_level,
    output logic [3:0] o_supply_override,
    // Microphone controls
    output logic [1:0] o_pdm_microphone_phase,
    output logic [1:0] o_pdm_microphone_rate,
    // Pin controls
    output logic o_source_select,
    output logic o_headphone_amp_on,
    output logic o_output_path_on,
    output logic o_input_path_on,
    output logic [2:0] o_bias_voltage_choice,
    output logic o_sense_start,
    output logic o_sense_ring_side
);
    localparam int TX_BITS = cvj_pkg::TX_BITS;

    logic [2:0] bclk_q;
    logic [1:0] sync_q;
    logic [1:0] sdo_q;
    logic [1:0] pres_q;
    logic [1:0] conv_q;
    logic pres_d;
    logic [27:0] cmd_sh;
    logic [4:0] cmd_cnt;
    logic cmd_go;
    logic [7:0] supply_reg;
    logic [3:0] mic_reg;
    logic sel_reg;
    logic [7:0] pinctl_reg;
    logic [7:0] event_reg;
    logic [30:0] imp_reg;
    logic measuring_reg;
    logic start_reg;
    logic ring_reg;
    logic fg_pend_reg;
    logic rsp_pend_reg;
    logic [31:0] rsp_reg;
    logic evt_pend_reg;
    logic [TX_BITS-1:0] tx_sh;
    logic [5:0] tx_cnt;
    logic tx_busy;
    logic sdi_reg;

    // Link edges, found from the synchronised bit clock
    wire rise = bclk_q[1] & ~bclk_q[2];
    wire fall = ~bclk_q[1] & bclk_q[2];

    wire [7:0] nid = cmd_sh[27:20];
    wire [11:0] verb = cmd_sh[19:8];
    wire [7:0] pl = cmd_sh[7:0];
    wire hit_afg = cmd_go && nid == cvj_pkg::AFG_NID;
    wire hit_pin = cmd_go && nid == cvj_pkg::PIN_NID;

    wire wr_supply = hit_afg && verb == cvj_pkg::V_SET_SUPPLY;
    wire wr_mic = hit_afg && verb == cvj_pkg::V_SET_MIC;
    wire wr_fg_reset = hit_afg && verb == cvj_pkg::V_FG_RESET
        && pl == cvj_pkg::P_RESET_EXEC;
    wire wr_sel = hit_pin && verb == cvj_pkg::V_SET_SEL;
    wire wr_pinctl = hit_pin && verb == cvj_pkg::V_SET_PINCTL;
    wire wr_event = hit_pin && verb == cvj_pkg::V_SET_EVENT;
    wire wr_sense = hit_pin && verb == cvj_pkg::V_SET_SENSE;
    wire is_param = hit_pin && verb == cvj_pkg::V_GET_PARAM;

    // Bias codes not offered by the pin are replaced by high impedance
    wire bias_ok = cvj_pkg::BIAS_OPTIONS[pl[2:0]];
    wire [7:0] pinctl_wr = {pl[7:5], 2'b00, bias_ok ? pl[2:0] : 3'b000};

    wire [6:0] list_len = conv_q[1] ? cvj_pkg::LIST_LEN_TWO : cvj_pkg::LIST_LEN_ONE;
    wire [7:0] entry1 = conv_q[1] ? cvj_pkg::SECOND_CONVERTER : 8'h00;

    // Reads; every set verb and unknown verb falls through to zero
    wire [31:0] rd_data =
        (hit_afg && verb == cvj_pkg::V_GET_SUPPLY) ? {24'h0, supply_reg} :
        (hit_afg && verb == cvj_pkg::V_GET_MIC) ? {28'h0, mic_reg} :
        (is_param && pl == cvj_pkg::P_WIDGET_CAPS) ? cvj_pkg::WIDGET_CAPS_VAL :
        (is_param && pl == cvj_pkg::P_PIN_CAPS) ? cvj_pkg::PIN_CAPS_VAL :
        (is_param && pl == cvj_pkg::P_LIST_LEN) ? {25'h0, list_len} :
        (hit_pin && verb == cvj_pkg::V_GET_LIST) ?
            {16'h0, entry1, cvj_pkg::FIRST_CONVERTER} :
        (hit_pin && verb == cvj_pkg::V_GET_SEL) ? {31'h0, sel_reg} :
        (hit_pin && verb == cvj_pkg::V_GET_PINCTL) ? {24'h0, pinctl_reg} :
        (hit_pin && verb == cvj_pkg::V_GET_EVENT) ? {24'h0, event_reg} :
        (hit_pin && verb == cvj_pkg::V_GET_SENSE) ? {pres_q[1], imp_reg} :
        32'h0000_0000;

    // Group reset waits until its own acknowledge has left the wire
    wire fg_clear = fg_pend_reg & ~rsp_pend_reg & ~tx_busy;
    wire ctl_clr = i_srst | fg_clear;

    wire jack_ins = pres_q[1] & ~pres_d;
    wire sense_done = measuring_reg & i_sense_valid;
    wire evt_hit = event_reg[cvj_pkg::EVT_EN_BIT] & (jack_ins | sense_done);
    wire load_rsp = ~tx_busy & rsp_pend_reg;
    wire load_evt = ~tx_busy & ~rsp_pend_reg & evt_pend_reg & ~fg_pend_reg;
    wire [31:0] evt_word = {event_reg[5:0], 26'h0};

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            bclk_q <= 3'h0;
            sync_q <= 2'h0;
            sdo_q <= 2'h0;
            pres_q <= 2'h0;
            conv_q <= 2'h0;
            pres_d <= 1'b0;
        end else begin
            bclk_q <= {bclk_q[1:0], link.bclk};
            sync_q <= {sync_q[0], link.sync};
            sdo_q <= {sdo_q[0], link.sdo};
            pres_q <= {pres_q[0], i_jack_present};
            conv_q <= {conv_q[0], i_second_converter_on};
            pres_d <= pres_q[1];
        end
    end

    // Command frame: bits taken on link rising edges while sync is high
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cmd_sh <= 28'h0;
            cmd_cnt <= 5'h0;
            cmd_go <= 1'b0;
        end else begin
            cmd_go <= 1'b0;
            if (rise && sync_q[1]) begin
                cmd_sh <= {cmd_sh[26:0], sdo_q[1]};
                if (cmd_cnt == 5'(cvj_pkg::CMD_BITS - 1)) begin
                    cmd_cnt <= 5'h0;
                    cmd_go <= 1'b1;
                end else begin
                    cmd_cnt <= cmd_cnt + 5'h1;
                end
            end else if (rise) begin
                cmd_cnt <= 5'h0;
            end
        end
    end

    // Controls; the group reset clears them like the system reset.
    // No configuration default control lives here, so none has to be spared.
    always_ff @(posedge i_clk_sys) begin
        if (ctl_clr) begin
            supply_reg <= cvj_pkg::SUPPLY_RST;
            mic_reg <= cvj_pkg::MIC_RST;
            sel_reg <= 1'b0;
            pinctl_reg <= 8'h00;
            event_reg <= 8'h00;
        end else begin
            if (wr_supply) begin
                supply_reg <= pl;
            end
            if (wr_mic) begin
                mic_reg <= pl[3:0];
            end
            if (wr_sel) begin
                sel_reg <= pl[0];
            end
            if (wr_pinctl) begin
                pinctl_reg <= pinctl_wr;
            end
            if (wr_event) begin
                event_reg <= {pl[7], 1'b0, pl[5:0]};
            end
        end
    end

    // Impedance sense: all ones while busy or without a reading
    always_ff @(posedge i_clk_sys) begin
        if (ctl_clr) begin
            imp_reg <= cvj_pkg::IMPEDANCE_NONE;
            measuring_reg <= 1'b0;
            start_reg <= 1'b0;
            ring_reg <= 1'b0;
        end else begin
            start_reg <= wr_sense;
            if (wr_sense) begin
                imp_reg <= cvj_pkg::IMPEDANCE_NONE;
                measuring_reg <= 1'b1;
                ring_reg <= pl[0];
            end else if (sense_done) begin
                imp_reg <= i_sense_value;
                measuring_reg <= 1'b0;
            end
        end
    end

    // Pending answers; a new event wins over the clear by loading
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            fg_pend_reg <= 1'b0;
            rsp_pend_reg <= 1'b0;
            rsp_reg <= 32'h0;
            evt_pend_reg <= 1'b0;
        end else begin
            if (wr_fg_reset) begin
                fg_pend_reg <= 1'b1;
            end else if (fg_clear) begin
                fg_pend_reg <= 1'b0;
            end
            if (cmd_go) begin
                rsp_pend_reg <= 1'b1;
                rsp_reg <= rd_data;
            end else if (load_rsp) begin
                rsp_pend_reg <= 1'b0;
            end
            evt_pend_reg <= evt_hit | (evt_pend_reg & ~load_evt & ~fg_clear);
        end
    end

    // Answer frame: start bit, event flag, 32 data bits, driven on falling edges
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            tx_sh <= '0;
            tx_cnt <= 6'h0;
            tx_busy <= 1'b0;
            sdi_reg <= 1'b0;
        end else if (load_rsp) begin
            tx_sh <= {2'b10, rsp_reg};
            tx_cnt <= 6'h0;
            tx_busy <= 1'b1;
        end else if (load_evt) begin
            tx_sh <= {2'b11, evt_word};
            tx_cnt <= 6'h0;
            tx_busy <= 1'b1;
        end else if (fall) begin
            sdi_reg <= tx_busy & tx_sh[TX_BITS-1];
            if (tx_busy) begin
                tx_sh <= {tx_sh[TX_BITS-2:0], 1'b0};
                tx_cnt <= tx_cnt + 6'h1;
                tx_busy <= tx_cnt != 6'(TX_BITS - 1);
            end
        end
    end

    assign link.sdi = sdi_reg;
    assign o_anti_pop_fast_ramp = supply_reg[cvj_pkg::SUP_RAMP_BIT];
    assign o_analog_current_trim = supply_reg[cvj_pkg::SUP_TRIM_LSB +: 2];
    assign o_digital_audio_input_level = supply_reg[cvj_pkg::SUP_LEVEL_BIT];
    assign o_supply_override = supply_reg[3:0];
    assign o_pdm_microphone_phase = mic_reg[cvj_pkg::MIC_PHASE_LSB +: 2];
    assign o_pdm_microphone_rate = mic_reg[1:0];
    assign o_source_select = sel_reg;
    assign o_headphone_amp_on = pinctl_reg[cvj_pkg::PIN_HP_BIT];
    assign o_output_path_on = pinctl_reg[cvj_pkg::PIN_OUT_BIT];
    assign o_input_path_on = pinctl_reg[cvj_pkg::PIN_IN_BIT];
    assign o_bias_voltage_choice = pinctl_reg[2:0];
    assign o_sense_start = start_reg;
    assign o_sense_ring_side = ring_reg;
endmodule : cvj_codec

// file: design/cvj_host.sv
// Controller end: APB registers, bit clock divider, command and answer framing.
// Assumes the codec answers every command; one command is outstanding at a time.
`timescale 1ns/100ps
module cvj_host #(
    parameter int LINK_HALF = cvj_pkg::LINK_HALF
) (
    // System
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Link
    cvj_link_if.host link
);
    typedef enum logic {RX_IDLE, RX_DATA} cvj_rx_type;

    logic [7:0] div_cnt;
    logic bclk_reg;
    logic sync_reg;
    logic sdo_reg;
    logic [1:0] sdi_q;
    logic start_pend;
    logic [27:0] cmd_reg;
    logic [27:0] tx_sh;
    logic [4:0] tx_left;
    cvj_rx_type rx_state;
    logic [5:0] rx_cnt;
    logic [31:0] rx_sh;
    logic busy_reg;
    logic resp_flag;
    logic evt_flag;
    logic [31:0] resp_reg;
    logic [31:0] evt_reg;

    wire tick = div_cnt == 8'(LINK_HALF - 1);
    wire fall_now = tick & bclk_reg;
    wire setup = i_psel & ~i_penable;
    wire access = i_psel & i_penable & o_pready;
    wire a_cmd = i_paddr == cvj_pkg::HA_CMD;
    wire a_st = i_paddr == cvj_pkg::HA_STATUS;
    wire a_rsp = i_paddr == cvj_pkg::HA_RESP;
    wire a_evt = i_paddr == cvj_pkg::HA_EVENT;
    wire bad = ~(a_cmd | a_st | a_rsp | a_evt) | (a_cmd & i_pwrite & busy_reg);
    wire cmd_wr = access & i_pwrite & a_cmd & ~o_pslverr;
    wire st_wr = access & i_pwrite & a_st;
    wire [31:0] status = {29'h0, evt_flag, resp_flag, busy_reg};
    wire [31:0] rd_mux = a_st ? status : a_rsp ? resp_reg : a_evt ? evt_reg : 32'h0;
    wire rx_done = fall_now && rx_state == RX_DATA && rx_cnt == 6'(cvj_pkg::RSP_BITS - 1);
    wire rx_evt = rx_done & rx_sh[31];
    wire rx_rsp = rx_done & ~rx_sh[31];

    // APB: pready in the cycle after setup, so every access takes two cycles
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup & bad;
            o_prdata <= setup ? rd_mux : 32'h0;
        end
    end

    // Flags: hardware set wins over write-one-to-clear in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            busy_reg <= 1'b0;
            resp_flag <= 1'b0;
            evt_flag <= 1'b0;
            cmd_reg <= 28'h0;
            resp_reg <= 32'h0;
            evt_reg <= 32'h0;
        end else begin
            busy_reg <= cmd_wr | (busy_reg & ~rx_rsp);
            resp_flag <= rx_rsp | (resp_flag & ~(st_wr & i_pwdata[cvj_pkg::ST_RESP]));
            evt_flag <= rx_evt | (evt_flag & ~(st_wr & i_pwdata[cvj_pkg::ST_EVENT]));
            if (cmd_wr) begin
                cmd_reg <= i_pwdata[27:0];
            end
            if (rx_rsp) begin
                resp_reg <= {rx_sh[30:0], sdi_q[1]};
            end
            if (rx_evt) begin
                evt_reg <= {rx_sh[30:0], sdi_q[1]};
            end
        end
    end

    // Bit clock divider and command frame, changed on the clock's falling edge
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            div_cnt <= 8'h0;
            bclk_reg <= 1'b0;
            sync_reg <= 1'b0;
            sdo_reg <= 1'b0;
            start_pend <= 1'b0;
            tx_sh <= 28'h0;
            tx_left <= 5'h0;
        end else begin
            div_cnt <= tick ? 8'h0 : div_cnt + 8'h1;
            if (tick) begin
                bclk_reg <= ~bclk_reg;
            end
            if (cmd_wr) begin
                start_pend <= 1'b1;
            end
            if (fall_now) begin
                if (tx_left != 5'h0) begin
                    sdo_reg <= tx_sh[27];
                    tx_sh <= {tx_sh[26:0], 1'b0};
                    tx_left <= tx_left - 5'h1;
                end else if (start_pend) begin
                    sync_reg <= 1'b1;
                    sdo_reg <= cmd_reg[27];
                    tx_sh <= {cmd_reg[26:0], 1'b0};
                    tx_left <= 5'(cvj_pkg::CMD_BITS - 1);
                    start_pend <= 1'b0;
                end else begin
                    sync_reg <= 1'b0;
                    sdo_reg <= 1'b0;
                end
            end
        end
    end

    // Answer frame, sampled just before each falling edge
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sdi_q <= 2'h0;
            rx_state <= RX_IDLE;
            rx_cnt <= 6'h0;
            rx_sh <= 32'h0;
        end else begin
            sdi_q <= {sdi_q[0], link.sdi};
            if (fall_now) begin
                unique case (rx_state)
                    RX_IDLE: begin
                        rx_cnt <= 6'h0;
                        if (sdi_q[1]) begin
                            rx_state <= RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        rx_sh <= {rx_sh[30:0], sdi_q[1]};
                        rx_cnt <= rx_cnt + 6'h1;
                        if (rx_done) begin
                            rx_state <= RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    assign link.bclk = bclk_reg;
    assign link.sync = sync_reg;
    assign link.sdo = sdo_reg;
endmodule : cvj_host

// file: tb/cvj_link_checker.sv
// Wire checker for the serial verb link: bit clock, framing and idle levels.
// Assumes the host runs with the default divider of four system cycles per half.
`timescale 1ns/100ps
module cvj_link_checker (
    // System
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Link
    input wire logic bclk,
    input wire logic sync,
    input wire logic sdo,
    input wire logic sdi
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    property p_idle_after_reset;
        $fell(i_srst) |-> !bclk && !sync && !sdo && !sdi;
    endproperty
    a_idle_after_reset: assert property (p_idle_after_reset)
        else $error("link not idle after reset");
    property p_bclk_half;
        $rose(bclk) |-> bclk [*4] ##1 !bclk;
    endproperty
    a_bclk_half: assert property (p_bclk_half)
        else $error("bit clock high phase wrong");
    property p_sync_fall_edge;
        $changed(sync) |-> $fell(bclk);
    endproperty
    a_sync_fall_edge: assert property (p_sync_fall_edge)
        else $error("frame marker moved off a clock fall");
    property p_sdo_fall_edge;
        $changed(sdo) |-> $fell(bclk);
    endproperty
    a_sdo_fall_edge: assert property (p_sdo_fall_edge)
        else $error("command bit moved off a clock fall");
    // A command is 28 bit periods of 8 system cycles
    property p_frame_len;
        $rose(sync) |-> (sync throughout (##223 1'b1)) ##1 !sync;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("command frame length wrong");
    property p_answer_start;
        $fell(sync) |-> !sdi ##[1:16] sdi;
    endproperty
    a_answer_start: assert property (p_answer_start)
        else $error("no answer after command");
    property p_sdi_low_phase;
        $changed(sdi) |-> !bclk;
    endproperty
    a_sdi_low_phase: assert property (p_sdi_low_phase)
        else $error("answer bit moved while bit clock high");
    property p_quiet_in_frame;
        sync |-> !sdi;
    endproperty
    a_quiet_in_frame: assert property (p_quiet_in_frame)
        else $error("answer line busy during command");
endmodule : cvj_link_checker

// file: tb/testbench.sv
// Drives the controller end over APB and the codec's pins; both ends share one clock.
// Assumes one verb outstanding at a time and the default link divider.
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    localparam logic [7:0] NF = cvj_pkg::AFG_NID;
    localparam logic [7:0] NP = cvj_pkg::PIN_NID;
    logic i_clk_sys = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [7:0] i_paddr = 0, pl, pm, pp, ex;
    logic [31:0] i_pwdata = 0, o_prdata, rd;
    logic o_pready, o_pslverr, er, jack = 0, strap = 1, sv = 0;
    logic [30:0] sval = 0;
    logic ramp, lvl, sel, hp, oe, ie, sst, ring;
    logic [1:0] trim, ph, rt;
    logic [3:0] ovr;
    logic [2:0] bias;
    int err_count = 0, tests_run = 0, starts = 0;
    cvj_link_if link ();
    cvj_host cvj_host_inst (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .link(link));
    cvj_codec cvj_codec_inst (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .link(link),
        .i_jack_present(jack), .i_second_converter_on(strap), .i_sense_valid(sv),
        .i_sense_value(sval), .o_anti_pop_fast_ramp(ramp), .o_analog_current_trim(trim),
        .o_digital_audio_input_level(lvl), .o_supply_override(ovr),
        .o_pdm_microphone_phase(ph), .o_pdm_microphone_rate(rt), .o_source_select(sel),
        .o_headphone_amp_on(hp), .o_output_path_on(oe), .o_input_path_on(ie),
        .o_bias_voltage_choice(bias), .o_sense_start(sst), .o_sense_ring_side(ring));
    cvj_link_checker chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .bclk(link.bclk),
        .sync(link.sync), .sdo(link.sdo), .sdi(link.sdi));
    always @(posedge i_clk_sys) if (sst === 1'b1) starts <= starts + 1;
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic tmo();
        err_count++;
        $display("MISMATCH t=%0t wait ran out", $time);
        summarize();
    endtask : tmo
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        i_psel <= 1; i_penable <= 0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1;
        do begin @(posedge i_clk_sys); n++; end while (o_pready !== 1'b1 && n < 50);
        r = o_prdata; e = o_pslverr;
        i_psel <= 0; i_penable <= 0;
        @(posedge i_clk_sys);
        if (n >= 50) tmo();
    endtask : apb
    // Polls one status bit, reads the answer register behind it and clears the bit
    task automatic fetch(input int b, input logic [7:0] a, output logic [31:0] r);
        logic [31:0] s;
        int n;
        n = 0;
        do begin apb(0, cvj_pkg::HA_STATUS, 0, s, er); n++; end
        while (s[b] !== 1'b1 && n < 3000);
        if (n >= 3000) tmo();
        apb(0, a, 0, r, er);
        apb(1, cvj_pkg::HA_STATUS, 32'h1 << b, s, er);
    endtask : fetch
    task automatic ck(input logic [7:0] n, input logic [11:0] v, input logic [7:0] p,
        input logic [31:0] x);
        logic [31:0] r;
        apb(1, cvj_pkg::HA_CMD, {4'h0, n, v, p}, r, er);
        fetch(cvj_pkg::ST_RESP, cvj_pkg::HA_RESP, r);
        `CHK(r, x)
    endtask : ck
    task automatic ev(input logic [31:0] x);
        logic [31:0] r;
        fetch(cvj_pkg::ST_EVENT, cvj_pkg::HA_EVENT, r);
        `CHK(r, x)
    endtask : ev
    initial begin
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_srst <= 0;
        @(posedge i_clk_sys);
        `CHK({lvl, rt, ramp, bias}, 7'h60)
        ck(NF, 12'hfe6, 0, 32'h10);
        ck(NF, 12'hff0, 0, 32'h2);
        ck(NP, 12'hf09, 0, 32'h7fff_ffff);
        ck(NP, 12'hf00, 8'h09, 32'h0040_0181);
        ck(NP, 12'hf00, 8'h0c, 32'h173f);
        ck(NP, 12'hf00, 8'h0e, 32'h2);
        ck(NP, 12'hf02, 0, 32'h1110);
        strap <= 0;
        ck(NP, 12'hf00, 8'h0e, 32'h1);
        ck(NP, 12'hf02, 0, 32'h10);
        for (int i = 0; i < 4; i++) begin
            pl = {i[0], i[1:0], ~i[0], 4'(4'h9 << i)};
            pm = {4'hf, 2'(i), 2'(3 - i)};
            ck(NF, 12'h7e6, pl, 0);
            ck(NF, 12'hfe6, 0, {24'h0, pl});
            `CHK({ramp, trim, lvl, ovr}, pl)
            ck(NF, 12'h7f0, pm, 0);
            ck(NF, 12'hff0, 0, {28'h0, pm[3:0]});
            `CHK({ph, rt}, pm[3:0])
        end
        for (int i = 0; i < 8; i++) begin
            pp = {3'(i), 2'b11, 3'(i)};
            ex = {pp[7:5], 2'b00, (i == 3 || i > 4) ? 3'h0 : 3'(i)};
            ck(NP, 12'h707, pp, 0);
            ck(NP, 12'hf07, 0, {24'h0, ex});
            `CHK({hp, oe, ie, bias}, {ex[7:5], ex[2:0]})
        end
        ck(NP, 12'h701, 8'hff, 0);
        ck(NP, 12'hf01, 0, 32'h1);
        `CHK(sel, 1'b1)
        ck(NP, 12'h708, 8'hed, 0);
        ck(NP, 12'hf08, 0, 32'had);
        jack <= 1;
        ev(32'hb400_0000);
        ck(NP, 12'h709, 8'h01, 0);
        `CHK({ring, starts}, {1'b1, 32'd1})
        ck(NP, 12'hf09, 0, 32'hffff_ffff);
        sval <= 31'h1234; sv <= 1;
        @(posedge i_clk_sys);
        sv <= 0;
        ev(32'hb400_0000);
        ck(NP, 12'hf09, 0, {1'b1, 31'h1234});
        ck(NP, 12'h709, 8'h00, 0);
        `CHK({ring, starts}, {1'b0, 32'd2})
        ck(NF, 12'h7ff, 8'h00, 0);
        ck(NF, 12'hfe6, 0, 32'h10);
        ck(NF, 12'hff0, 0, 32'h2);
        ck(NP, 12'hf07, 0, 0);
        ck(NP, 12'hf08, 0, 0);
        ck(NP, 12'hf01, 0, 0);
        ck(NP, 12'hf09, 0, 32'hffff_ffff);
        apb(0, 8'h40, 0, rd, er);
        `CHK({er, rd}, {1'b1, 32'h0})
        summarize();
    end
endmodule : testbench
